// [hw/bioz_drive_pkg.sv]
// Purpose: shared constants, types and decoders for the impedance drive block
// Assumes: 20 MHz core clock, byte-addressed 32-bit register bus
// Notes: frequency figures in Hz, drive levels in microamps

package bioz_drive_pkg;

    // core clock
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int unsigned PHASE_SLOTS = 32;

    // register byte offsets
    localparam int unsigned ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_CHAN_CFG = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_GEN_CFG = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_APPLIED = 5'h10;

    // impedance_channel_config fields
    localparam int unsigned CFG_W = 24;
    localparam int unsigned CFG_RATE_BIT = 23;
    localparam int unsigned CFG_DLPF_LSB = 12;
    localparam int unsigned CFG_FCGEN_LSB = 8;
    localparam int unsigned CFG_CGMON_BIT = 7;
    localparam int unsigned CFG_CGMAG_LSB = 4;
    localparam int unsigned CFG_PHOFF_LSB = 0;
    localparam logic [CFG_W-1:0] CFG_RESET = 24'h201800;
    localparam logic [1:0] DLPF_4HZ = 2'h1;
    localparam logic [1:0] DLPF_16HZ = 2'h3;

    // general_config fields
    localparam int unsigned GCFG_W = 3;
    localparam int unsigned GCFG_MSEL_LSB = 0;
    localparam int unsigned GCFG_CHAN_EN_BIT = 2;
    localparam logic [GCFG_W-1:0] GCFG_RESET = 3'h0;

    // status and mask fields
    localparam int unsigned STAT_W = 2;
    localparam int unsigned STAT_ALERT_BIT = 0;
    localparam int unsigned STAT_MAGBAD_BIT = 1;
    localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

    // master clock and modulation frequencies
    localparam logic [17:0] MASTER_CLOCK_SELECT_32768 = 18'h08000;
    localparam logic [17:0] MASTER_CLOCK_SELECT_32000 = 18'h07D00;
    localparam logic [17:0] MASTER_CLOCK_SELECT_31968 = 18'h07CE0;
    localparam logic [17:0] FREQ_X2_A = 18'h14000;
    localparam logic [17:0] FREQ_X2_B = 18'h13880;
    localparam logic [17:0] FREQ_X1_A = 18'h0A000;
    localparam logic [17:0] FREQ_X1_B = 18'h09C40;
    localparam logic [17:0] FREQ_H_A = 18'h0471C;
    localparam logic [17:0] FREQ_H_B = 18'h04574;

    // drive level per magnitude code, index 0 is off
    localparam logic [7:0][6:0] DRIVE_UA_TBL = {7'h60, 7'h50, 7'h40, 7'h30,
        7'h20, 7'h10, 7'h08, 7'h00};

    typedef enum logic {GEN_OFF = 1'b0, GEN_RUN = 1'b1} gen_state_t;

    function automatic logic [17:0] mod_freq_hz(input logic [1:0] msel,
        input logic [3:0] code);
        logic [17:0] base;
        logic fam_a;
        base = (msel == 2'h0) ? MASTER_CLOCK_SELECT_32768 :
            (msel == 2'h3) ? MASTER_CLOCK_SELECT_31968 : MASTER_CLOCK_SELECT_32000;
        fam_a = (msel == 2'h0) || (msel == 2'h3);
        unique case (code)
            4'h0: mod_freq_hz = base << 2;
            4'h1: mod_freq_hz = fam_a ? FREQ_X2_A : FREQ_X2_B;
            4'h2: mod_freq_hz = fam_a ? FREQ_X1_A : FREQ_X1_B;
            4'h3: mod_freq_hz = fam_a ? FREQ_H_A : FREQ_H_B;
            4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9:
                mod_freq_hz = base >> (code - 4'h2);
            default: mod_freq_hz = base >> 8;
        endcase
    endfunction

    // phase offset in 11.25 degree slots; coarse codes drop low bits
    function automatic logic [4:0] phase_slots(input logic [3:0] code,
        input logic [3:0] phoff);
        if (code == 4'h0)
            phase_slots = {1'b0, phoff[3:2], 2'h0};
        else if (code == 4'h1)
            phase_slots = {1'b0, phoff[3:1], 1'b0};
        else
            phase_slots = {1'b0, phoff};
    endfunction

    // magnitude ceiling shrinks as the modulation frequency drops
    function automatic logic mag_allowed(input logic [3:0] code,
        input logic [2:0] mag);
        if (code <= 4'h3)
            mag_allowed = 1'b1;
        else if (code == 4'h4)
            mag_allowed = (mag != 3'h7);
        else if (code == 4'h5)
            mag_allowed = (mag <= 3'h3);
        else if (code == 4'h6)
            mag_allowed = (mag <= 3'h2);
        else
            mag_allowed = (mag <= 3'h1);
    endfunction

endpackage

// [hw/pin_sync.sv]
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels, not pulses
// Notes: first stage feeds only the second stage

`timescale 1ns/10ps

module pin_sync #(
    parameter int unsigned WIDTH = 2
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.meta = i_async;
        next_s.sync = s.meta;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s <= '0;
        else if (i_ce)
            s <= next_s;
    end

    assign o_sync = s.sync;
endmodule // pin_sync

// [hw/modulation_nco.sv]
// Purpose: modulation phase generator, 32 slots per period
// Assumes: i_freq_hz * 32 stays below MOD_HZ
// Notes: restarts at slot 0 whenever i_run is low

`timescale 1ns/10ps

module modulation_nco
    import bioz_drive_pkg::*;
#(
    parameter int unsigned MOD_HZ = CLK_HZ,
    parameter int unsigned ACC_W = 25
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // control
    input wire logic i_run,
    input wire logic [17:0] i_freq_hz,
    // phase out
    output logic [4:0] o_slot,
    output logic o_period_end
);
    localparam logic [ACC_W:0] MOD = (ACC_W+1)'(MOD_HZ);

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic [4:0] slot;
    } nco_state_t;

    nco_state_t s;
    nco_state_t next_s;
    logic [ACC_W:0] sum;
    logic wrap;

    always_comb
    begin
        next_s = s;
        sum = {1'b0, s.acc} + (ACC_W+1)'({i_freq_hz, 5'h00});
        wrap = (sum >= MOD);
        if (!i_run)
        begin
            next_s.acc = '0;
            next_s.slot = 5'h00;
        end
        else if (wrap)
        begin
            next_s.acc = ACC_W'(sum - MOD);
            next_s.slot = s.slot + 5'h01;
        end
        else
            next_s.acc = ACC_W'(sum);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s <= '0;
        else if (i_ce)
            s <= next_s;
    end

    assign o_slot = s.slot;
    assign o_period_end = i_run && wrap && (s.slot == 5'h1F);
endmodule // modulation_nco

// [hw/bioz_drive_cfg.sv]
// Purpose: impedance drive configuration, generator control and monitor
// Assumes: Avalon-MM slave, one-wait-state answer, 20 MHz clock
// Notes: compliance comparator pins are asynchronous and synchronised here

`timescale 1ns/10ps

module bioz_drive_cfg
    import bioz_drive_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic o_waitrequest,
    output logic [31:0] o_readdata,
    // compliance comparators, asynchronous
    input wire logic [1:0] i_compliance_fault,
    // drive outputs
    output logic o_drive_out_pos,
    output logic o_drive_out_pos_oe,
    output logic o_drive_out_neg,
    output logic o_drive_out_neg_oe,
    output logic [6:0] o_drive_current_ua,
    // monitor, filter and interrupt
    output logic o_drive_compliance_monitor_en,
    output logic o_drive_compliance_alert,
    output logic [1:0] o_lowpass_select,
    output logic o_irq
);
    typedef struct packed {
        logic [CFG_W-1:0] cfg;
        logic [GCFG_W-1:0] gcfg;
        logic [STAT_W-1:0] stat;
        logic [STAT_W-1:0] mask;
        logic waitreq;
        logic [31:0] rdata;
        gen_state_t gen;
        logic [3:0] ap_fcgen;
        logic [2:0] ap_mag;
        logic [4:0] ap_slots;
        logic pos;
        logic neg;
        logic oe;
        logic [6:0] ua;
        logic mon_en;
        logic alert;
        logic [1:0] lpf;
        logic irq;
    } state_t;

    localparam state_t S_RESET = '{
        cfg: CFG_RESET,
        gcfg: GCFG_RESET,
        stat: STAT_RESET,
        mask: STAT_RESET,
        waitreq: 1'b1,
        rdata: 32'h00000000,
        gen: GEN_OFF,
        ap_fcgen: 4'h0,
        ap_mag: 3'h0,
        ap_slots: 5'h00,
        pos: 1'b0,
        neg: 1'b1,
        oe: 1'b0,
        ua: 7'h00,
        mon_en: 1'b0,
        alert: 1'b0,
        lpf: DLPF_4HZ,
        irq: 1'b0
    };

    state_t s;
    state_t next_s;

    logic [1:0] fault_sync;
    logic [4:0] nco_slot;
    logic nco_end;
    logic [17:0] freq_hz;

    // config fields as stored, and the effective lowpass code
    logic [3:0] cfg_fcgen;
    logic [2:0] cfg_mag;
    logic [3:0] cfg_phoff;
    logic [1:0] cfg_dlpf;
    logic [1:0] eff_dlpf;
    logic [1:0] msel;
    logic chan_en;

    assign cfg_fcgen = s.cfg[CFG_FCGEN_LSB +: 4];
    assign cfg_mag = s.cfg[CFG_CGMAG_LSB +: 3];
    assign cfg_phoff = s.cfg[CFG_PHOFF_LSB +: 4];
    assign cfg_dlpf = s.cfg[CFG_DLPF_LSB +: 2];
    assign msel = s.gcfg[GCFG_MSEL_LSB +: 2];
    assign chan_en = s.gcfg[GCFG_CHAN_EN_BIT];

    // the slow rate cannot run the 16 Hz filter, fall back to 4 Hz
    assign eff_dlpf = (s.cfg[CFG_RATE_BIT] && cfg_dlpf == DLPF_16HZ) ?
        DLPF_4HZ : cfg_dlpf;

    // rate follows master select live, ratio follows the applied code
    assign freq_hz = mod_freq_hz(msel, s.ap_fcgen);

    pin_sync #(
        .WIDTH(2)
    ) u_fault_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_async(i_compliance_fault),
        .o_sync(fault_sync)
    );

    modulation_nco #(
        .MOD_HZ(CLK_HZ),
        .ACC_W(25)
    ) u_nco (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_run(s.gen == GEN_RUN),
        .i_freq_hz(freq_hz),
        .o_slot(nco_slot),
        .o_period_end(nco_end)
    );

    function automatic logic [31:0] merge_be(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge_be = (old & ~m) | (wd & m);
    endfunction

    always_comb
    begin
        logic [31:0] wmerged;
        logic [4:0] rel;
        logic [STAT_W-1:0] set_ev;
        wmerged = 32'h00000000;
        rel = 5'h00;
        set_ev = '0;
        next_s = s;

        // bus: answer one cycle after the request is seen
        next_s.waitreq = 1'b1;
        if ((i_read || i_write) && s.waitreq)
        begin
            next_s.waitreq = 1'b0;
            next_s.rdata = 32'h00000000;
            if (i_read)
            begin
                unique case (i_address)
                    ADDR_CHAN_CFG:
                    begin
                        next_s.rdata[CFG_W-1:0] = s.cfg;
                        next_s.rdata[CFG_DLPF_LSB +: 2] = eff_dlpf;
                    end
                    ADDR_GEN_CFG:
                        next_s.rdata[GCFG_W-1:0] = s.gcfg;
                    ADDR_STATUS:
                        next_s.rdata[STAT_W-1:0] = s.stat;
                    ADDR_MASK:
                        next_s.rdata[STAT_W-1:0] = s.mask;
                    ADDR_APPLIED:
                        next_s.rdata[12:0] = {s.gen == GEN_RUN, s.ap_slots,
                            s.ap_mag, s.ap_fcgen};
                    default:
                        next_s.rdata = 32'h00000000;
                endcase
            end
        end

        // write takes effect on the edge that sees waitrequest low
        if (i_write && !s.waitreq)
        begin
            unique case (i_address)
                ADDR_CHAN_CFG:
                begin
                    wmerged = merge_be({8'h00, s.cfg}, i_writedata,
                        i_byteenable);
                    next_s.cfg = wmerged[CFG_W-1:0];
                    // flag a magnitude too large for its frequency
                    if (!mag_allowed(wmerged[CFG_FCGEN_LSB +: 4],
                        wmerged[CFG_CGMAG_LSB +: 3]))
                        set_ev[STAT_MAGBAD_BIT] = 1'b1;
                end
                ADDR_GEN_CFG:
                begin
                    wmerged = merge_be({29'h00000000, s.gcfg}, i_writedata,
                        i_byteenable);
                    next_s.gcfg = wmerged[GCFG_W-1:0];
                end
                ADDR_STATUS:
                    if (i_byteenable[0])
                        next_s.stat = s.stat & ~i_writedata[STAT_W-1:0];
                ADDR_MASK:
                    if (i_byteenable[0])
                        next_s.mask = i_writedata[STAT_W-1:0];
                default:
                    next_s.stat = next_s.stat;
            endcase
        end

        // generator: settings are taken only while idle or at period end
        if (s.gen == GEN_OFF || nco_end)
        begin
            next_s.ap_fcgen = cfg_fcgen;
            next_s.ap_mag = cfg_mag;
            next_s.ap_slots = phase_slots(cfg_fcgen, cfg_phoff);
            next_s.gen = (cfg_mag != 3'h0 && chan_en) ? GEN_RUN : GEN_OFF;
        end

        // square drive, shifted by the phase offset in 11.25 degree slots
        rel = nco_slot - s.ap_slots;
        next_s.pos = !rel[4];
        // own flop so the negative pin is not an inverter output
        next_s.neg = rel[4];
        next_s.oe = (s.gen == GEN_RUN);
        next_s.ua = (s.gen == GEN_RUN) ? DRIVE_UA_TBL[s.ap_mag] : 7'h00;

        // compliance monitor
        next_s.mon_en = s.cfg[CFG_CGMON_BIT] && chan_en &&
            (s.gen == GEN_RUN);
        next_s.alert = s.mon_en && (|fault_sync);
        set_ev[STAT_ALERT_BIT] = s.alert;

        // set wins over a same-cycle clear
        next_s.stat = next_s.stat | set_ev;
        next_s.irq = |(next_s.stat & next_s.mask);
        next_s.lpf = eff_dlpf;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s <= S_RESET;
        else if (i_ce)
            s <= next_s;
    end

    assign o_waitrequest = s.waitreq;
    assign o_readdata = s.rdata;
    assign o_drive_out_pos = s.pos;
    assign o_drive_out_pos_oe = s.oe;
    assign o_drive_out_neg = s.neg;
    assign o_drive_out_neg_oe = s.oe;
    assign o_drive_current_ua = s.ua;
    assign o_drive_compliance_monitor_en = s.mon_en;
    assign o_drive_compliance_alert = s.alert;
    assign o_lowpass_select = s.lpf;
    assign o_irq = s.irq;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence bus_req_s;
        (i_read || i_write) && o_waitrequest && i_ce;
    endsequence

    sequence bus_ack_s;
        !o_waitrequest ##0 i_ce ##1 o_waitrequest;
    endsequence

    sequence gen_hold_s;
        s.gen == GEN_RUN && !nco_end && i_ce;
    endsequence

    bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
        else $error("bus request not answered in one cycle");

    gen_hold_a: assert property (gen_hold_s |=>
        $stable(s.ap_fcgen) && $stable(s.ap_mag) && $stable(s.ap_slots))
        else $error("generator settings changed inside a period");

    off_float_a: assert property ((s.gen == GEN_OFF && i_ce) |=>
        !o_drive_out_pos_oe && !o_drive_out_neg_oe && o_drive_current_ua == 7'h00)
        else $error("drive outputs not floating while generator off");

    drive_level_a: assert property ((s.gen == GEN_RUN && i_ce) |=>
        o_drive_current_ua == DRIVE_UA_TBL[$past(s.ap_mag)])
        else $error("drive level does not match magnitude code");

    monitor_gate_a: assert property (o_drive_compliance_monitor_en |->
        $past(s.cfg[CFG_CGMON_BIT] && chan_en && s.gen == GEN_RUN))
        else $error("compliance monitor enabled without its conditions");

    alert_gate_a: assert property (o_drive_compliance_alert |->
        $past(o_drive_compliance_monitor_en))
        else $error("compliance alert while monitor disabled");

    alert_sticky_a: assert property ((o_drive_compliance_alert && i_ce) |=>
        s.stat[STAT_ALERT_BIT])
        else $error("compliance alert not recorded in status");

    lpf_remap_a: assert property ((s.cfg[CFG_RATE_BIT] &&
        cfg_dlpf == DLPF_16HZ && i_ce) |=> o_lowpass_select == DLPF_4HZ)
        else $error("unsupported lowpass not remapped to 4 Hz");

    phase_coarse_a: assert property ((s.gen == GEN_OFF && i_ce &&
        cfg_fcgen == 4'h0) |=> s.ap_slots == {1'b0, $past(cfg_phoff[3:2]), 2'h0})
        else $error("code zero phase not in 45 degree steps");

    phase_mid_a: assert property ((s.gen == GEN_OFF && i_ce &&
        cfg_fcgen == 4'h1) |=> s.ap_slots == {1'b0, $past(cfg_phoff[3:1]), 1'b0})
        else $error("code one phase not in 22.5 degree steps");

    phase_fine_a: assert property ((s.gen == GEN_OFF && i_ce &&
        cfg_fcgen >= 4'h2) |=> s.ap_slots == {1'b0, $past(cfg_phoff)})
        else $error("fine phase offset not applied");

    freq_shift_a: assert property ((s.ap_fcgen == 4'h3) |->
        freq_hz > MASTER_CLOCK_SELECT_32000 / 2)
        else $error("mid-band frequency not shifted upward");
endmodule // bioz_drive_cfg

// [testbench/bioz_drive_cfg_bench.sv]
// Purpose: self-checking bench for the impedance drive configuration block
// Assumes: one-wait-state register answer, generator gated by channel enable
// Notes: waits are sized from the longest modulation period in use

`timescale 1ns/10ps

module bioz_drive_cfg_bench
    import bioz_drive_pkg::*;
();
    typedef struct {
        logic [3:0] code;
        logic [3:0] ph;
        logic [2:0] mag;
        logic [6:0] ua;
        int plo;
    } row_t;
    // period bounds allow a clock of nco jitter either side
    row_t rows [7] = '{'{4'h0, 4'hF, 3'h1, 7'h08, 151},
        '{4'h1, 4'hF, 3'h2, 7'h10, 242}, '{4'h2, 4'hF, 3'h3, 7'h20, 486},
        '{4'h3, 4'h5, 3'h4, 7'h30, 1096}, '{4'h2, 4'hA, 3'h5, 7'h40, 486},
        '{4'h1, 4'h3, 3'h6, 7'h50, 242}, '{4'h0, 4'h7, 3'h7, 7'h60, 151}};
    logic i_clk, i_rst_n, i_ce, i_read, i_write, o_waitrequest, o_irq;
    logic [ADDR_W-1:0] i_address;
    logic [31:0] i_writedata, o_readdata;
    logic [3:0] i_byteenable;
    logic [1:0] i_compliance_fault, o_lowpass_select;
    logic o_drive_out_pos, o_drive_out_pos_oe, o_drive_out_neg;
    logic o_drive_out_neg_oe, o_drive_compliance_monitor_en;
    logic o_drive_compliance_alert;
    logic [6:0] o_drive_current_ua;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int per;

    bioz_drive_cfg DUT (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_waitrequest(o_waitrequest), .o_readdata(o_readdata),
        .i_compliance_fault(i_compliance_fault),
        .o_drive_out_pos(o_drive_out_pos),
        .o_drive_out_pos_oe(o_drive_out_pos_oe),
        .o_drive_out_neg(o_drive_out_neg),
        .o_drive_out_neg_oe(o_drive_out_neg_oe),
        .o_drive_current_ua(o_drive_current_ua),
        .o_drive_compliance_monitor_en(o_drive_compliance_monitor_en),
        .o_drive_compliance_alert(o_drive_compliance_alert),
        .o_lowpass_select(o_lowpass_select), .o_irq(o_irq)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ceiling is nearly three times the expected run
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    // holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        i_address <= a;
        i_write <= wr;
        i_read <= !wr;
        i_writedata <= d;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_waitrequest !== 1'b0 && n < 50);
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        if (n >= 50)
            check(32'(o_waitrequest), 32'h0);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic wait_pos(input logic v, inout int n);
        while (o_drive_out_pos !== v && n < 5000)
        begin
            @(posedge i_clk);
            n++;
        end
    endtask

    // clocks between two rising edges of the positive drive
    task automatic measure(output int cyc);
        int n;
        int m;
        n = 0;
        wait_pos(1'b0, n);
        wait_pos(1'b1, n);
        m = n;
        wait_pos(1'b0, n);
        wait_pos(1'b1, n);
        cyc = n - m;
    endtask

    function automatic logic [31:0] cfg(input logic [3:0] c,
        input logic [3:0] p, input logic [2:0] g, input logic mon);
        return {20'h00000, c, mon, g, p};
    endfunction

    // coarse codes keep only the upper phase bits, in 11.25 degree slots
    function automatic logic [4:0] slots(input logic [3:0] c,
        input logic [3:0] p);
        if (c == 4'h0)
            return {1'b0, p[3:2], 2'h0};
        if (c == 4'h1)
            return {1'b0, p[3:1], 1'b0};
        return {1'b0, p};
    endfunction

    initial
    begin
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        i_read = 1'b0;
        i_write = 1'b0;
        i_address = 5'h00;
        i_writedata = 32'h0;
        i_byteenable = 4'hF;
        i_compliance_fault = 2'h0;
        wait_cyc(6);
        check(32'(o_waitrequest), 32'h1);
        check(32'(o_drive_out_pos_oe), 32'h0);
        check(32'(o_lowpass_select), 32'h1);
        wait_cyc(6);
        i_rst_n <= 1'b1;
        rdc(ADDR_CHAN_CFG, 32'h00201800);
        rdc(ADDR_GEN_CFG, 32'h0);
        rdc(ADDR_STATUS, 32'h0);
        rdc(ADDR_MASK, 32'h0);
        wr(5'h14, 32'hFFFFFFFF);
        rdc(5'h14, 32'h0);
        // unsupported lowpass: stored as written, read and used as 4 Hz
        wr(ADDR_CHAN_CFG, 32'h00803000);
        rdc(ADDR_CHAN_CFG, 32'h00801000);
        check(32'(o_lowpass_select), 32'h1);
        wr(ADDR_CHAN_CFG, 32'h00003000);
        rdc(ADDR_CHAN_CFG, 32'h00003000);
        check(32'(o_lowpass_select), 32'h3);
        wr(ADDR_CHAN_CFG, 32'h00802000);
        wait_cyc(2);
        check(32'(o_lowpass_select), 32'h2);
        wr(ADDR_CHAN_CFG, cfg(4'h0, 4'h0, 3'h1, 1'b0));
        wait_cyc(4);
        check(32'(o_drive_out_pos_oe), 32'h0);
        wr(ADDR_GEN_CFG, 32'h4);
        wait_cyc(4);
        check(32'(o_drive_out_neg_oe), 32'h1);
        check(32'(o_drive_current_ua), 32'h08);
        measure(per);
        check_range(per, 151, 154);
        wr(ADDR_GEN_CFG, 32'h5);
        wait_cyc(400);
        measure(per);
        check_range(per, 155, 158);
        wr(ADDR_GEN_CFG, 32'h4);
        foreach (rows[i])
        begin
            wr(ADDR_CHAN_CFG,
                cfg(rows[i].code, rows[i].ph, rows[i].mag, 1'b0));
            wait_cyc(2400);
            check(32'(o_drive_out_neg), 32'(!o_drive_out_pos));
            check(32'(o_drive_current_ua), 32'(rows[i].ua));
            check(32'(o_drive_out_pos_oe), 32'h1);
            rdc(ADDR_APPLIED, {19'h0, 1'b1, slots(rows[i].code, rows[i].ph),
                rows[i].mag, rows[i].code});
            measure(per);
            check_range(per, rows[i].plo, rows[i].plo + 3);
        end
        // monitor stays silent while its enable bit is clear
        i_compliance_fault <= 2'h1;
        wait_cyc(8);
        check(32'(o_drive_compliance_alert), 32'h0);
        rdc(ADDR_STATUS, 32'h0);
        wr(ADDR_CHAN_CFG, cfg(4'h0, 4'h7, 3'h7, 1'b1));
        wait_cyc(8);
        check(32'(o_drive_compliance_monitor_en), 32'h1);
        check(32'(o_drive_compliance_alert), 32'h1);
        check(32'(o_irq), 32'h0);
        wr(ADDR_MASK, 32'h1);
        wait_cyc(2);
        check(32'(o_irq), 32'h1);
        i_compliance_fault <= 2'h0;
        wait_cyc(8);
        check(32'(o_drive_compliance_alert), 32'h0);
        rdc(ADDR_STATUS, 32'h1);
        wr(ADDR_STATUS, 32'h1);
        rdc(ADDR_STATUS, 32'h0);
        check(32'(o_irq), 32'h0);
        wr(ADDR_GEN_CFG, 32'h0);
        wait_cyc(400);
        check(32'(o_drive_compliance_monitor_en), 32'h0);
        wr(ADDR_GEN_CFG, 32'h4);
        // too much current for a low frequency is flagged, still applied
        wr(ADDR_MASK, 32'h2);
        wr(ADDR_CHAN_CFG, cfg(4'h5, 4'h0, 3'h4, 1'b0));
        wait_cyc(2);
        check(32'(o_irq), 32'h1);
        wr(ADDR_STATUS, 32'h2);
        rdc(ADDR_STATUS, 32'h0);
        wait_cyc(400);
        check(32'(o_drive_current_ua), 32'h30);
        wr(ADDR_CHAN_CFG, cfg(4'h0, 4'h0, 3'h0, 1'b0));
        wait_cyc(10000);
        check(32'(o_drive_out_pos_oe), 32'h0);
        check(32'(o_drive_out_neg_oe), 32'h0);
        check(32'(o_drive_current_ua), 32'h0);
        report_and_stop();
    end
endmodule // bioz_drive_cfg_bench
